// ===== inc/sis_pkg.sv
// Purpose: Shared constants and types for the interface setup register block.
// Assumes: Seven-bit register addresses and eight-bit registers.
// Notes:   Field positions follow the interface setup register layout.
package sis_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register map and field layout.
	localparam int        SIS_ADDR_W        = 7;
	localparam logic [6:0] SIS_ADDR_SETUP   = 7'h00;
	localparam logic [6:0] SIS_ADDR_FIRST   = 7'h01;
	localparam logic [7:0] SIS_SETUP_RESET  = 8'h10;
	localparam logic [7:0] SIS_SCRATCH_RESET = 8'h00;
	localparam int        SIS_BIT_RST_HI    = 7;
	localparam int        SIS_BIT_DIR       = 5;
	localparam int        SIS_BIT_SOE       = 4;
	localparam int        SIS_BIT_RST_LO    = 0;
	localparam int        SIS_BIT_READ      = 7;
	localparam logic [2:0] SIS_LAST_BIT     = 3'h7;

	////////////////////////////////////////////////////////////////////////
	// Serial pins carried together through the synchroniser.
	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic sdi;
	} sis_pins_t;

	// Frame phases.
	typedef enum logic [2:0] {
		SIS_IDLE  = 3'b001,
		SIS_INSTR = 3'b010,
		SIS_DATA  = 3'b100
	} sis_state_t;

endpackage

// ===== hw/sis_core.sv
// Purpose: Serial register slave holding the interface setup register.
// Assumes: Mode 0 serial link, sampled by clk_i; host keeps its own rules.
// Notes:   Instruction byte is read flag plus seven-bit address, then data.
// Summary of operation
// - Both reset bits in one write reset registers.
// - Soft reset does not restore setup register; the same write stores its direction bit.
// - Upper reset bit alone does nothing.
// - Direction zero decrements address per byte.
// - Direction one increments address per byte.
// - Setup register at 0x00, resets 0x10.
// - Lower reset bit sits at bit 0.
// - Streaming steps address for every data byte.
module sis_core
	import sis_pkg::*;
#(
	parameter int NUM_SCRATCH = 8
) (
	// Clock, reset and enable.
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	// Serial link pins.
	input  wire logic sclk_i,
	input  wire logic cs_n_i,
	input  wire logic sdi_i,
	output logic      sdo_o,
	output logic      sdo_oe_o,
	// Status toward the rest of the device.
	output logic      soft_reset_o,
	output logic      step_up_o
);

	////////////////////////////////////////////////////////////////////////
	// Pin synchroniser: three stages, a change counts when stages two and three agree.
	sis_pins_t  pins_s1;
	sis_pins_t  pins_s2;
	sis_pins_t  pins_s3;
	sis_pins_t  pins;
	sis_pins_t  pins_prev;
	wire sis_pins_t pins_in    = '{sclk: sclk_i, cs_n: cs_n_i, sdi: sdi_i};
	wire sis_pins_t pins_agree = ~(pins_s2 ^ pins_s3);
	wire sis_pins_t next_pins  = (pins_s3 & pins_agree) | (pins & ~pins_agree);

	// Samples and filters the link pins; idle levels are clock low and select high.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pins_s1   <= '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0};
			pins_s2   <= '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0};
			pins_s3   <= '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0};
			pins      <= '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0};
			pins_prev <= '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0};
		end else if (ce_i) begin
			pins_s1   <= pins_in;
			pins_s2   <= pins_s1;
			pins_s3   <= pins_s2;
			pins      <= next_pins;
			pins_prev <= pins;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Frame state and shifters.
	sis_state_t                  state;
	logic [2:0]                  bit_cnt;
	logic [7:0]                  rx;
	logic [7:0]                  tx;
	logic [SIS_ADDR_W-1:0]       addr;
	logic                        rd;
	logic                        dir;
	logic [7:0]                  scratch [NUM_SCRATCH];

	// Edge and byte decoding.
	wire                  sclk_rise  = pins.sclk & ~pins_prev.sclk & ~pins.cs_n;
	wire                  sclk_fall  = ~pins.sclk & pins_prev.sclk & ~pins.cs_n;
	wire [7:0]            rx_next    = {rx[6:0], pins.sdi};
	wire                  instr_ph   = (state != SIS_DATA);
	wire                  byte_done  = ce_i & sclk_rise & (bit_cnt == SIS_LAST_BIT);
	wire                  instr_done = byte_done & instr_ph;
	wire                  data_done  = byte_done & ~instr_ph;
	wire                  wr_byte    = data_done & ~rd;
	wire                  wr_setup   = wr_byte & (addr == SIS_ADDR_SETUP);
	wire                  do_soft    = wr_setup & rx_next[SIS_BIT_RST_HI] & rx_next[SIS_BIT_RST_LO];
	wire [SIS_ADDR_W-1:0] stepped    = dir ? addr + 7'h01 : addr - 7'h01;

	// Read mux for the byte about to be shifted out.
	wire [SIS_ADDR_W-1:0] rd_addr  = instr_ph ? rx_next[6:0] : stepped;
	wire [SIS_ADDR_W-1:0] scr_idx  = rd_addr - SIS_ADDR_FIRST;
	wire                  scr_hit  = (rd_addr >= SIS_ADDR_FIRST) && (scr_idx < 7'(NUM_SCRATCH));
	wire [7:0]            setup_rd = (SIS_SETUP_RESET & ~(8'h01 << SIS_BIT_DIR)) | (8'(dir) << SIS_BIT_DIR);
	wire [7:0]            rd_data  = (rd_addr == SIS_ADDR_SETUP) ? setup_rd :
	                                 scr_hit ? scratch[scr_idx[$clog2(NUM_SCRATCH)-1:0]] : 8'h00;

	// Write slot for the current data byte; addresses past the scratch range are dropped.
	wire [SIS_ADDR_W-1:0] scr_wr_idx = addr - SIS_ADDR_FIRST;
	wire                  scr_wr_hit = (addr >= SIS_ADDR_FIRST) && (scr_wr_idx < 7'(NUM_SCRATCH));

	// Frame sequencing: instruction byte, then data bytes while select stays low.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state    <= SIS_IDLE;
			bit_cnt  <= 3'h0;
			rx       <= 8'h00;
			tx       <= 8'h00;
			addr     <= SIS_ADDR_SETUP;
			rd       <= 1'b0;
			sdo_oe_o <= 1'b0;
		end else if (ce_i) begin
			if (pins.cs_n) begin
				state    <= SIS_IDLE;
				bit_cnt  <= 3'h0;
				sdo_oe_o <= 1'b0;
			end else begin
				if (state == SIS_IDLE) begin
					state <= SIS_INSTR;
				end
				if (sclk_rise) begin
					rx      <= rx_next;
					bit_cnt <= bit_cnt + 3'h1;
				end
				if (instr_done) begin
					state    <= SIS_DATA;
					rd       <= rx_next[SIS_BIT_READ];
					addr     <= rx_next[6:0];
					sdo_oe_o <= rx_next[SIS_BIT_READ];
					tx       <= rd_data;
				end else if (data_done) begin
					addr <= stepped;
					tx   <= rd_data;
				end else if (sclk_fall && bit_cnt != 3'h0 && state == SIS_DATA) begin
					tx <= {tx[6:0], 1'b0};
				end
			end
		end
	end

	assign sdo_o     = tx[7];
	assign step_up_o = dir;

	////////////////////////////////////////////////////////////////////////
	// Register writes and software reset; only the direction bit is writable at 0x00.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			dir          <= SIS_SETUP_RESET[SIS_BIT_DIR];
			soft_reset_o <= 1'b0;
			for (int i = 0; i < NUM_SCRATCH; i++) begin
				scratch[i] <= SIS_SCRATCH_RESET;
			end
		end else if (ce_i) begin
			soft_reset_o <= do_soft;
			if (wr_setup) begin
				dir <= rx_next[SIS_BIT_DIR];
			end
			if (do_soft) begin
				for (int i = 0; i < NUM_SCRATCH; i++) begin
					scratch[i] <= SIS_SCRATCH_RESET;
				end
			end else if (wr_byte && scr_wr_hit) begin
				scratch[scr_wr_idx[$clog2(NUM_SCRATCH)-1:0]] <= rx_next;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks.
	sequence seq_write_start;
		instr_done && !rx_next[SIS_BIT_READ];
	endsequence

	sequence seq_read_start;
		instr_done && rx_next[SIS_BIT_READ];
	endsequence

	// Both halves of the reset request inside one write to the setup register.
	sequence seq_soft_request;
		wr_setup && rx_next[SIS_BIT_RST_HI] && rx_next[SIS_BIT_RST_LO];
	endsequence

	// A read of the setup register presents the flag set, both reset bits clear and the live direction.
	a_setup_value: assert property (@(posedge clk_i) disable iff (rst_i)
		(seq_read_start ##0 (rx_next[SIS_ADDR_W-1:0] == SIS_ADDR_SETUP)) |=>
			(tx[SIS_BIT_SOE] && !tx[SIS_BIT_RST_HI] && !tx[SIS_BIT_RST_LO] && tx[SIS_BIT_DIR] == dir))
		else $error("setup register read value wrong");
	// The pulse follows one cycle after the completing data byte.
	a_soft_reset_pair: assert property (@(posedge clk_i) disable iff (rst_i)
		seq_soft_request |=> soft_reset_o)
		else $error("soft reset not raised");
	a_half_no_reset: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_setup && !(rx_next[SIS_BIT_RST_HI] && rx_next[SIS_BIT_RST_LO])) |=> !soft_reset_o)
		else $error("soft reset from one bit");
	a_low_bit_needed: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_setup && !rx_next[SIS_BIT_RST_LO]) |=> !soft_reset_o)
		else $error("soft reset without low bit");
	// Only the direction bit of a setup write is kept.
	a_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_setup |=> (dir == $past(rx_next[SIS_BIT_DIR])))
		else $error("direction bit not stored");
	a_scratch_cleared: assert property (@(posedge clk_i) disable iff (rst_i)
		do_soft |=> (scratch[0] == SIS_SCRATCH_RESET) && (dir == $past(rx_next[SIS_BIT_DIR])))
		else $error("soft reset result wrong");
	a_step_down: assert property (@(posedge clk_i) disable iff (rst_i)
		(data_done && !dir) |=> addr == $past(addr) - 7'h01)
		else $error("address not decremented");
	a_step_up: assert property (@(posedge clk_i) disable iff (rst_i)
		(data_done && dir) |=> addr == $past(addr) + 7'h01)
		else $error("address not incremented");
	a_write_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		seq_write_start |=> !sdo_oe_o && state == SIS_DATA)
		else $error("output driven on write");
	a_read_drive: assert property (@(posedge clk_i) disable iff (rst_i)
		seq_read_start |=> sdo_oe_o ##0 (sdo_o == $past(rd_data[7])))
		else $error("read byte not presented");
	// A soft reset is reported for exactly one enabled cycle.
	a_single_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		(soft_reset_o && ce_i) |=> !soft_reset_o)
		else $error("soft reset pulse too long");
	// Seeing the select released ends the frame and frees the data line.
	a_oe_release: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && pins.cs_n) |=> (!sdo_oe_o && state == SIS_IDLE && bit_cnt == 3'h0))
		else $error("frame not closed on deselect");
	// With the enable low nothing may move, the frame logic and the registers alike.
	a_freeze_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!ce_i |=> ($stable(state) && $stable(addr) && $stable(tx) && $stable(dir) && $stable(pins)))
		else $error("state moved while enable low");

endmodule

// ===== bench/sis_host_model.sv
// Purpose: Behavioural serial host that drives frames into the setup register block.
// Assumes: Mode 0 link, one bit every ten system clocks, giving an 80 ns serial period.
// Notes:   Signals change only at rising system clock edges; read data is taken just before each falling edge.
module sis_host_model (
	// System clock.
	input  wire logic clk_i,
	// Serial link pins.
	input  wire logic sdo_i,
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      sdi_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// The link rests with its clock low and the select released.
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		sdi_o  = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Open a frame and leave setup time before the first data bit.
	task automatic sel();
		@(posedge clk_i);
		cs_n_o <= 1'b0;
		repeat (5) @(posedge clk_i);
	endtask

	// Shift one byte out MSB first while collecting the returned byte.
	task automatic bite(input logic [7:0] w, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			sdi_o <= w[i];
			repeat (5) @(posedge clk_i);
			sclk_o <= 1'b1;
			// Take the bit one clock before the fall, clear of the edge on which the block reloads.
			repeat (4) @(posedge clk_i);
			r[i] = sdo_i;
			@(posedge clk_i);
			sclk_o <= 1'b0;
		end
	endtask

	// Close the frame; the data line is flipped so a stale level is never trusted.
	task automatic desel();
		repeat (5) @(posedge clk_i);
		cs_n_o <= 1'b1;
		sdi_o  <= ~sdi_o;
		repeat (6) @(posedge clk_i);
	endtask
endmodule

// ===== bench/testbench.sv
// Purpose: Self-checking bench for the interface setup register block.
// Assumes: Mode 0 link; clock enable is dropped once, for the whole of one write frame.
// Notes:   Random data bytes come from a fixed seed so every run repeats.
module testbench;
	import sis_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic       clk_i = 1'b0;
	logic       rst_i = 1'b1;
	logic       ce_i  = 1'b1;
	logic       sclk, cs_n, sdi, sdo_o, sdo_oe_o, soft_reset_o, step_up_o;
	logic [7:0] q[4] = '{default: 8'h00};
	logic [7:0] d[4];
	int         failures, tests_run, pulses, cycles, p0, oe_cycles, oe0;
	// A released data line shows the inverse of its last level, so a stale bit is never read as good.
	wire        sdo_line = sdo_oe_o ? sdo_o : ~sdo_o;

	// System clock at 125 MHz.
	always #4 clk_i = ~clk_i;

	sis_core dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi),
		.sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .soft_reset_o(soft_reset_o), .step_up_o(step_up_o));
	sis_host_model host (.clk_i(clk_i), .sdo_i(sdo_line), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi));

	// Count soft reset pulses and cut a hung run short.
	always @(posedge clk_i) begin
		cycles++;
		if (soft_reset_o === 1'b1) pulses++;
		if (sdo_oe_o === 1'b1) oe_cycles++;
		if (cycles == 20000) begin
			failures++;
			results();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Expected setup register contents for a given direction bit.
	function automatic logic [7:0] exp_setup(input logic dir);
		return {2'b00, dir, 1'b1, 4'h0};
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One frame: instruction byte then n data bytes from q, read data lands back in q.
	task automatic xfer(input logic [7:0] ins, input int n);
		logic [7:0] r;
		host.sel();
		host.bite(ins, r);
		for (int i = 0; i < n; i++) begin
			host.bite(q[i], r);
			q[i] = r;
		end
		host.desel();
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		q[0] = v;
		xfer({1'b0, a}, 1);
	endtask

	task automatic results();
		$display("comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		void'($urandom(32'h811fd2df));
		for (int i = 0; i < 4; i++) d[i] = 8'($urandom);
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		check({7'h00, step_up_o}, 8'h00);
		oe0 = oe_cycles;
		xfer(8'h80, 1);
		check(q[0], exp_setup(1'b0));
		check({7'h00, (oe_cycles - oe0) > 80}, 8'h01);
		oe0 = oe_cycles;
		wr(SIS_ADDR_SETUP, 8'h6e);
		check(8'(oe_cycles - oe0), 8'h00);
		xfer(8'h80, 1);
		check(q[0], exp_setup(1'b1));
		check({7'h00, step_up_o}, 8'h01);
		// A write sent while the enable is low must leave no trace.
		ce_i <= 1'b0;
		wr(SIS_ADDR_SETUP, 8'h10);
		ce_i <= 1'b1;
		check({7'h00, step_up_o}, 8'h01);
		q = d;
		xfer(8'h01, 3);
		xfer(8'h81, 3);
		for (int i = 0; i < 3; i++) check(q[i], d[i]);
		wr(SIS_ADDR_SETUP, 8'h10);
		q = d;
		xfer(8'h03, 2);
		xfer(8'h82, 1);
		check(q[0], d[1]);
		xfer(8'h83, 2);
		check(q[0], d[0]);
		check(q[1], d[1]);
		p0 = pulses;
		wr(SIS_ADDR_SETUP, 8'h80);
		wr(SIS_ADDR_SETUP, 8'h01);
		xfer(8'h83, 1);
		check(q[0], d[0]);
		check(8'(pulses), 8'(p0));
		wr(SIS_ADDR_SETUP, 8'h20);
		wr(SIS_ADDR_SETUP, 8'ha1);
		check(8'(pulses), 8'(p0 + 1));
		xfer(8'h80, 1);
		check(q[0], exp_setup(1'b1));
		xfer(8'h83, 1);
		check(q[0], SIS_SCRATCH_RESET);
		// Reset again in mid-run: direction and scratch contents go back to power-up values.
		q = d;
		xfer(8'h01, 1);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		check({7'h00, step_up_o}, 8'h00);
		xfer(8'h80, 1);
		check(q[0], exp_setup(1'b0));
		xfer(8'h81, 1);
		check(q[0], SIS_SCRATCH_RESET);
		results();
	end
endmodule
